// ---- core/dram_mode_pkg.sv ----
// constants, field layouts and carrier types of the mode register subset
// assumes one clock domain; the controller logic shares mclk
//
// Overview of operation
// - activate code: 0 unknown, 1..6 mean 700K down to 200K, 7 reserved.
// - read-only bit 3 set means activates between refreshes are unlimited.
// - while the unlimited flag is one the activate code reads zero.
// - bit 7 one enables targeted row refresh, zero disables, reset disables.
// - a read-only byte shows per bank whether a repair resource remains.
// - any byte written to the test register at 1eh is taken and ignored.
// - the first pattern resets to 5ah and a later write may replace it.
// - calibration command 1000011b sends the first pattern, then the second.
// - each pattern byte goes low bit first on all data lanes, and on the mask pins when read inversion is on.
// - two invert registers invert data lanes, never the mask pins.
package dram_mode_pkg;

  localparam int ADDR_W = 6;
  localparam int BYTE_W = 8;
  localparam int BANKS = 8;
  localparam int DQ_LANES = 16;
  localparam int MASK_LANES = 2;
  localparam int CAL_BITS = 16;
  localparam int CAL_CNT_W = 5;

  localparam logic [ADDR_W-1:0] ADDR_LANE_INV_LOW = 6'h0f;
  localparam logic [ADDR_W-1:0] ADDR_LANE_INV_HIGH = 6'h14;
  localparam logic [ADDR_W-1:0] ADDR_ACT_TRR = 6'h18;
  localparam logic [ADDR_W-1:0] ADDR_REPAIR = 6'h19;
  localparam logic [ADDR_W-1:0] ADDR_TEST = 6'h1e;
  localparam logic [ADDR_W-1:0] ADDR_CAL_FIRST = 6'h20;
  localparam logic [ADDR_W-1:0] ADDR_CAL_SECOND = 6'h28;

  localparam int TRR_ENABLE_BIT = 7;
  localparam int TRR_BANK_LSB = 4;
  localparam int TRR_BANK_MSB = 6;
  localparam int UNLIMITED_BIT = 3;

  localparam logic [2:0] ACT_CODE_UNKNOWN = 3'h0;
  localparam logic [2:0] ACT_CODE_RESERVED = 3'h7;
  localparam logic TRR_ENABLE_RESET = 1'b0;
  localparam logic [2:0] TRR_BANK_RESET = 3'h0;
  localparam logic [BYTE_W-1:0] CAL_FIRST_RESET = 8'h5a;
  localparam logic [BYTE_W-1:0] CAL_SECOND_RESET = 8'h3c;
  localparam logic [BYTE_W-1:0] LANE_INV_RESET = 8'h00;
  localparam logic [BYTE_W-1:0] READ_ZERO = 8'h00;

  localparam logic [6:0] MPC_READ_CAL_OP = 7'h43;
  localparam logic [CAL_CNT_W-1:0] CAL_CNT_FIRST = 5'h01;
  localparam logic [CAL_CNT_W-1:0] CAL_CNT_LAST = 5'h10;

  typedef enum logic [1:0] {
    CMD_WRITE = 2'h0,
    CMD_READ  = 2'h1,
    CMD_MPC   = 2'h2,
    CMD_NONE  = 2'h3
  } cmd_kind_t;

  typedef struct packed {
    logic              valid;
    cmd_kind_t         kind;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] op;
  } cmd_t;

  typedef struct packed {
    logic              valid;
    logic [BYTE_W-1:0] data;
  } read_answer_t;

  typedef enum logic [1:0] {
    CAL_IDLE  = 2'b00,
    CAL_SHIFT = 2'b01
  } cal_state_t;

endpackage

// ---- core/mode_reg_byte.sv ----
// one writable mode register byte with a fixed value after reset
// assumes write enable and data come from logic on mclk
`timescale 1ns/10ps
module mode_reg_byte #(
  parameter int         WIDTH       = 8,
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             write_en,
  input  wire logic [WIDTH-1:0] write_data,
  output logic      [WIDTH-1:0] value
);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      value <= RESET_VALUE[WIDTH-1:0];
    end else if (write_en) begin
      value <= write_data;
    end
  end

endmodule

// ---- core/lane_serializer.sv ----
// one output lane of the calibration readout, low bit first
// assumes load and shift are never high together
`timescale 1ns/10ps
module lane_serializer #(
  parameter int WIDTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             load,
  input  wire logic             shift,
  input  wire logic             invert,
  input  wire logic [WIDTH-1:0] pattern,
  output logic                  bit_out
);

  logic [WIDTH-1:0] stored;
  logic [WIDTH-1:0] loaded;

  assign loaded = pattern ^ {WIDTH{invert}};

  // first bit leaves on the load edge, the rest one per shift
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stored  <= '0;
      bit_out <= 1'b0;
    end else if (load) begin
      stored  <= loaded >> 1;
      bit_out <= loaded[0];
    end else if (shift) begin
      stored  <= stored >> 1;
      bit_out <= stored[0];
    end
  end

endmodule

// ---- core/dram_mode_regs.sv ----
// mode register subset: activate capability, targeted row refresh control,
// repair resource readout, ignored test register and read calibration
// assumes the controller drives cmd on mclk and keeps mode register timing
`timescale 1ns/10ps
module dram_mode_regs #(
  parameter logic [2:0] MAX_ACTIVATE_CODE = 3'h0,
  parameter logic       UNLIMITED_ACTIVATE = 1'b0
) (
  input  wire logic                                        mclk,
  input  wire logic                                        resetn,
  input  wire dram_mode_pkg::cmd_t                         cmd,
  input  wire logic [dram_mode_pkg::BANKS-1:0]             repair_available,
  input  wire logic                                        dbi_read_enable,
  output dram_mode_pkg::read_answer_t                      read_answer,
  output logic                                             targeted_row_refresh_enable,
  output logic [2:0]                                       targeted_row_refresh_bank,
  output logic [dram_mode_pkg::DQ_LANES-1:0]               dq_out,
  output logic                                             dq_oe,
  output logic [dram_mode_pkg::MASK_LANES-1:0]             mask_inversion_pin_out,
  output logic                                             mask_inversion_pin_oe,
  output logic                                             cal_busy
);

  localparam int BW = dram_mode_pkg::BYTE_W;
  localparam int LANES = dram_mode_pkg::DQ_LANES + dram_mode_pkg::MASK_LANES;
  localparam int BANK_MSB = dram_mode_pkg::TRR_BANK_MSB;
  localparam int BANK_LSB = dram_mode_pkg::TRR_BANK_LSB;

  logic                                  is_write;
  logic                                  is_read;
  logic                                  is_cal_start;
  logic                                  write_inv_low;
  logic                                  write_inv_high;
  logic                                  write_cal_first;
  logic                                  write_cal_second;
  logic                                  write_act_trr;
  logic [BW-1:0]                         lane_inv_low;
  logic [BW-1:0]                         lane_inv_high;
  logic [BW-1:0]                         read_cal_pattern_first;
  logic [BW-1:0]                         read_cal_pattern_second;
  logic [2:0]                            max_activate_count;
  logic                                  unlimited_activate_flag;
  logic [BW-1:0]                         next_read_data;
  logic [dram_mode_pkg::CAL_BITS-1:0]    cal_pattern;
  logic [LANES-1:0]                      lane_invert;
  logic [LANES-1:0]                      lane_bits;
  logic                                  cal_load;
  logic                                  cal_shift;
  logic                                  cal_last;
  logic [dram_mode_pkg::CAL_CNT_W-1:0]   cal_count;
  dram_mode_pkg::cal_state_t             cal_state;

  // command decode
  assign is_write = cmd.valid && (cmd.kind == dram_mode_pkg::CMD_WRITE);
  assign is_read = cmd.valid && (cmd.kind == dram_mode_pkg::CMD_READ);
  assign is_cal_start = cmd.valid
                     && (cmd.kind == dram_mode_pkg::CMD_MPC)
                     && (cmd.op[6:0] == dram_mode_pkg::MPC_READ_CAL_OP)
                     && (cal_state == dram_mode_pkg::CAL_IDLE);

  assign write_inv_low = is_write
                      && (cmd.addr == dram_mode_pkg::ADDR_LANE_INV_LOW);
  assign write_inv_high = is_write
                       && (cmd.addr == dram_mode_pkg::ADDR_LANE_INV_HIGH);
  assign write_cal_first = is_write
                        && (cmd.addr == dram_mode_pkg::ADDR_CAL_FIRST);
  assign write_cal_second = is_write
                         && (cmd.addr == dram_mode_pkg::ADDR_CAL_SECOND);
  assign write_act_trr = is_write
                      && (cmd.addr == dram_mode_pkg::ADDR_ACT_TRR);
  // a write to the test address matches no register enable at all

  // activate capability is fixed by the part; reserved code reads unknown
  always_comb begin
    unlimited_activate_flag = UNLIMITED_ACTIVATE;
    if (UNLIMITED_ACTIVATE) begin
      max_activate_count = dram_mode_pkg::ACT_CODE_UNKNOWN;
    end else if (MAX_ACTIVATE_CODE == dram_mode_pkg::ACT_CODE_RESERVED) begin
      max_activate_count = dram_mode_pkg::ACT_CODE_UNKNOWN;
    end else begin
      max_activate_count = MAX_ACTIVATE_CODE;
    end
  end

  // targeted row refresh control; low nibble of the write is dropped
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      targeted_row_refresh_enable <= dram_mode_pkg::TRR_ENABLE_RESET;
      targeted_row_refresh_bank   <= dram_mode_pkg::TRR_BANK_RESET;
    end else if (write_act_trr) begin
      targeted_row_refresh_enable <=
        cmd.op[dram_mode_pkg::TRR_ENABLE_BIT];
      targeted_row_refresh_bank <=
        cmd.op[BANK_MSB:BANK_LSB];
    end
  end

  mode_reg_byte #(
    .WIDTH       (BW),
    .RESET_VALUE (dram_mode_pkg::LANE_INV_RESET)
  ) u_lane_inv_low (
    .mclk       (mclk),
    .resetn     (resetn),
    .write_en   (write_inv_low),
    .write_data (cmd.op),
    .value      (lane_inv_low)
  );

  mode_reg_byte #(
    .WIDTH       (BW),
    .RESET_VALUE (dram_mode_pkg::LANE_INV_RESET)
  ) u_lane_inv_high (
    .mclk       (mclk),
    .resetn     (resetn),
    .write_en   (write_inv_high),
    .write_data (cmd.op),
    .value      (lane_inv_high)
  );

  mode_reg_byte #(
    .WIDTH       (BW),
    .RESET_VALUE (dram_mode_pkg::CAL_FIRST_RESET)
  ) u_cal_first (
    .mclk       (mclk),
    .resetn     (resetn),
    .write_en   (write_cal_first),
    .write_data (cmd.op),
    .value      (read_cal_pattern_first)
  );

  mode_reg_byte #(
    .WIDTH       (BW),
    .RESET_VALUE (dram_mode_pkg::CAL_SECOND_RESET)
  ) u_cal_second (
    .mclk       (mclk),
    .resetn     (resetn),
    .write_en   (write_cal_second),
    .write_data (cmd.op),
    .value      (read_cal_pattern_second)
  );

  // read mux; write-only bits and unmapped addresses read as zero
  always_comb begin
    next_read_data = dram_mode_pkg::READ_ZERO;
    case (cmd.addr)
      dram_mode_pkg::ADDR_ACT_TRR: begin
        next_read_data[dram_mode_pkg::UNLIMITED_BIT] =
          unlimited_activate_flag;
        next_read_data[2:0] = max_activate_count;
      end
      dram_mode_pkg::ADDR_REPAIR: begin
        next_read_data = repair_available;
      end
      dram_mode_pkg::ADDR_TEST: begin
        next_read_data = dram_mode_pkg::READ_ZERO;
      end
      default: begin
        next_read_data = dram_mode_pkg::READ_ZERO;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      read_answer.valid <= 1'b0;
      read_answer.data  <= dram_mode_pkg::READ_ZERO;
    end else begin
      read_answer.valid <= is_read;
      if (is_read) begin
        read_answer.data <= next_read_data;
      end
    end
  end

  // calibration readout sequencer
  assign cal_last = (cal_count == dram_mode_pkg::CAL_CNT_LAST);
  assign cal_load = is_cal_start;
  assign cal_shift = (cal_state == dram_mode_pkg::CAL_SHIFT) && !cal_last;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cal_state <= dram_mode_pkg::CAL_IDLE;
      cal_count <= '0;
    end else begin
      case (cal_state)
        dram_mode_pkg::CAL_IDLE: begin
          if (is_cal_start) begin
            cal_state <= dram_mode_pkg::CAL_SHIFT;
            cal_count <= dram_mode_pkg::CAL_CNT_FIRST;
          end
        end
        dram_mode_pkg::CAL_SHIFT: begin
          if (cal_last) begin
            cal_state <= dram_mode_pkg::CAL_IDLE;
            cal_count <= '0;
          end else begin
            cal_count <= cal_count + dram_mode_pkg::CAL_CNT_W'(1);
          end
        end
        default: begin
          cal_state <= dram_mode_pkg::CAL_IDLE;
          cal_count <= '0;
        end
      endcase
    end
  end

  // output enables follow the sequencer; mask pins need read inversion on
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dq_oe                 <= 1'b0;
      mask_inversion_pin_oe <= 1'b0;
      cal_busy              <= 1'b0;
    end else if (is_cal_start) begin
      dq_oe                 <= 1'b1;
      mask_inversion_pin_oe <= dbi_read_enable;
      cal_busy              <= 1'b1;
    end else if ((cal_state == dram_mode_pkg::CAL_SHIFT) && cal_last) begin
      dq_oe                 <= 1'b0;
      mask_inversion_pin_oe <= 1'b0;
      cal_busy              <= 1'b0;
    end
  end

  // first pattern leaves first, second pattern is its tail
  assign cal_pattern = {read_cal_pattern_second,
                        read_cal_pattern_first};
  // low invert register covers lanes 7:0, high covers 15:8, mask pins never
  assign lane_invert = {{dram_mode_pkg::MASK_LANES{1'b0}},
                        lane_inv_high,
                        lane_inv_low};

  genvar lane;
  generate
    for (lane = 0; lane < LANES; lane = lane + 1) begin : g_lane
      lane_serializer #(
        .WIDTH (dram_mode_pkg::CAL_BITS)
      ) u_lane (
        .mclk    (mclk),
        .resetn  (resetn),
        .load    (cal_load),
        .shift   (cal_shift),
        .invert  (lane_invert[lane]),
        .pattern (cal_pattern),
        .bit_out (lane_bits[lane])
      );
    end
  endgenerate

  assign dq_out = lane_bits[dram_mode_pkg::DQ_LANES-1:0];
  assign mask_inversion_pin_out =
    lane_bits[LANES-1:dram_mode_pkg::DQ_LANES];

endmodule

// ---- testbench/ctrl_model.sv ----
// controller stand-in that issues commands to the mode register block
// assumes the bench calls send and the device samples cmd on mclk
`timescale 1ns/10ps
module ctrl_model (
  input  wire logic          mclk,
  output dram_mode_pkg::cmd_t cmd
);
  initial cmd = {1'b0, dram_mode_pkg::CMD_NONE, 6'h3f, 8'hff};
  // one command per call; idle fields are scrambled, not held
  task automatic send(input dram_mode_pkg::cmd_kind_t kind,
                      input logic [5:0] addr, input logic [7:0] op);
    @(posedge mclk);
    cmd <= {1'b1, kind, addr, op};
    @(posedge mclk);
    cmd <= {1'b0, dram_mode_pkg::CMD_NONE, ~addr, ~op};
  endtask
endmodule

// ---- testbench/mode_regs_sva.sv ----
// assertions on the ports of the mode register block
// assumes one clock mclk and an active low asynchronous reset
`timescale 1ns/10ps
module mode_regs_chk #(
  parameter logic [2:0] MAX_ACTIVATE_CODE  = 3'h0,
  parameter logic       UNLIMITED_ACTIVATE = 1'b0
) (
  input wire logic                         mclk,
  input wire logic                         resetn,
  input wire dram_mode_pkg::cmd_t          cmd,
  input wire logic [7:0]                   repair_available,
  input wire logic                         dbi_read_enable,
  input wire dram_mode_pkg::read_answer_t  read_answer,
  input wire logic                         targeted_row_refresh_enable,
  input wire logic [2:0]                   targeted_row_refresh_bank,
  input wire logic [15:0]                  dq_out,
  input wire logic                         dq_oe,
  input wire logic [1:0]                   mask_inversion_pin_out,
  input wire logic                         mask_inversion_pin_oe,
  input wire logic                         cal_busy
);
  localparam logic [7:0] ACT_EXP = UNLIMITED_ACTIVATE ? 8'h08 :
    (MAX_ACTIVATE_CODE == 3'h7) ? 8'h00 : {5'h00, MAX_ACTIVATE_CODE};
  logic rd, wr, cal_go;
  assign rd = cmd.valid && cmd.kind == dram_mode_pkg::CMD_READ;
  assign wr = cmd.valid && cmd.kind == dram_mode_pkg::CMD_WRITE
              && cmd.addr == dram_mode_pkg::ADDR_ACT_TRR;
  assign cal_go = cmd.valid && cmd.kind == dram_mode_pkg::CMD_MPC
                  && cmd.op[6:0] == dram_mode_pkg::MPC_READ_CAL_OP;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  AST_READ_ACT: assert property (
    rd && cmd.addr == dram_mode_pkg::ADDR_ACT_TRR |=>
    read_answer.valid && read_answer.data == ACT_EXP)
    else $error("activate readout wrong");
  AST_READ_REPAIR: assert property (
    rd && cmd.addr == dram_mode_pkg::ADDR_REPAIR |=>
    read_answer.valid && read_answer.data == $past(repair_available))
    else $error("repair readout wrong");
  AST_READ_TEST: assert property (
    rd && cmd.addr == dram_mode_pkg::ADDR_TEST |=>
    read_answer.valid && read_answer.data == 8'h00)
    else $error("test register readout not zero");
  AST_TRR_WRITE: assert property (
    wr |=> {targeted_row_refresh_enable, targeted_row_refresh_bank}
           == $past(cmd.op[7:4]))
    else $error("refresh control not updated");
  AST_TRR_HOLD: assert property (
    !wr |=> $stable(targeted_row_refresh_enable)
            && $stable(targeted_row_refresh_bank))
    else $error("refresh control changed without write");
  AST_CAL_START: assert property (
    cal_go && !cal_busy |=> dq_oe && cal_busy)
    else $error("calibration did not start");
  AST_CAL_LEN: assert property (
    $rose(dq_oe) |-> dq_oe[*8] ##1 dq_oe[*8] ##1 !dq_oe)
    else $error("calibration length not sixteen");
  AST_MASK_OE: assert property (
    cal_go && !cal_busy |=> mask_inversion_pin_oe == $past(dbi_read_enable))
    else $error("mask pin enable wrong");
  AST_MASK_SAME: assert property (
    mask_inversion_pin_oe |->
    mask_inversion_pin_out[0] == mask_inversion_pin_out[1] && dq_oe)
    else $error("mask pins differ");
  cover property (rd && cmd.addr == dram_mode_pkg::ADDR_REPAIR);
  cover property (cal_go && !cal_busy);
  cover property (wr);
endmodule
bind dram_mode_regs mode_regs_chk #(.MAX_ACTIVATE_CODE(MAX_ACTIVATE_CODE),
  .UNLIMITED_ACTIVATE(UNLIMITED_ACTIVATE)) chk_u (.mclk(mclk),
  .resetn(resetn), .cmd(cmd), .repair_available(repair_available),
  .dbi_read_enable(dbi_read_enable), .read_answer(read_answer),
  .targeted_row_refresh_enable(targeted_row_refresh_enable),
  .targeted_row_refresh_bank(targeted_row_refresh_bank), .dq_out(dq_out),
  .dq_oe(dq_oe), .mask_inversion_pin_out(mask_inversion_pin_out),
  .mask_inversion_pin_oe(mask_inversion_pin_oe), .cal_busy(cal_busy));

// ---- testbench/testbench.sv ----
// self-checking bench for the mode register block
// assumes ctrl_model issues commands and the checker is bound
`timescale 1ns/10ps
module testbench;
  logic                        mclk = 1'b0;
  logic                        resetn = 1'b0;
  logic [7:0]                  repair_available = 8'h00;
  logic                        dbi_read_enable = 1'b0;
  dram_mode_pkg::cmd_t         cmd;
  dram_mode_pkg::read_answer_t ans;
  dram_mode_pkg::read_answer_t ans_unl;
  logic                        trr_en;
  logic [2:0]                  trr_bank;
  logic [15:0]                 dq;
  logic [1:0]                  mask;
  logic                        dq_oe;
  logic                        mask_oe;
  logic                        busy;
  int                          fail_count = 0;
  int                          check_count = 0;
  int                          cycles = 0;
  always #2 mclk = ~mclk;
  ctrl_model ctrl_u (.mclk(mclk), .cmd(cmd));
  dram_mode_regs #(.MAX_ACTIVATE_CODE(3'h2),
    .UNLIMITED_ACTIVATE(1'b0)) dut_u (
    .mclk(mclk), .resetn(resetn), .cmd(cmd),
    .repair_available(repair_available),
    .dbi_read_enable(dbi_read_enable), .read_answer(ans),
    .targeted_row_refresh_enable(trr_en), .targeted_row_refresh_bank(trr_bank),
    .dq_out(dq), .dq_oe(dq_oe), .mask_inversion_pin_out(mask),
    .mask_inversion_pin_oe(mask_oe), .cal_busy(busy));
  // second copy reports unlimited activates with a nonzero code set
  dram_mode_regs #(.MAX_ACTIVATE_CODE(3'h5),
    .UNLIMITED_ACTIVATE(1'b1)) dut_unl (
    .mclk(mclk), .resetn(resetn), .cmd(cmd),
    .repair_available(repair_available),
    .dbi_read_enable(dbi_read_enable), .read_answer(ans_unl),
    .targeted_row_refresh_enable(), .targeted_row_refresh_bank(), .dq_out(),
    .dq_oe(), .mask_inversion_pin_out(), .mask_inversion_pin_oe(),
    .cal_busy());
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    ctrl_u.send(dram_mode_pkg::CMD_WRITE, a, d);
    #1;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    ctrl_u.send(dram_mode_pkg::CMD_READ, a, 8'h00);
    #1;
    check({ans.valid, ans.data}, {1'b1, exp});
  endtask
  // runs one readout and compares every bit time and the idle after it
  task automatic cal(input logic [15:0] inv, input logic [15:0] pat,
                     input logic dbi);
    ctrl_u.send(dram_mode_pkg::CMD_MPC, 6'h00, 8'h43);
    for (int k = 0; k < 17; k++) begin
      #1;
      if (k < 16)
        check({dq_oe, busy, mask_oe, dbi ? mask : 2'b00, dq}, {2'b11, dbi,
              dbi ? {2{pat[k]}} : 2'b00, {16{pat[k]}} ^ inv});
      else
        check({dq_oe, busy, mask_oe}, 24'h0);
      @(posedge mclk);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      wrap_up;
    end
  end
  initial begin
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    #1;
    check({trr_en, trr_bank}, 24'h0);
    rd(dram_mode_pkg::ADDR_ACT_TRR, 8'h02);
    check({ans_unl.valid, ans_unl.data}, 24'h108);
    for (int b = 0; b < 8; b++) begin
      wr(dram_mode_pkg::ADDR_ACT_TRR, {1'b1, b[2:0], 4'hf});
      check({trr_en, trr_bank}, {20'h0, 1'b1, b[2:0]});
    end
    rd(dram_mode_pkg::ADDR_ACT_TRR, 8'h02);
    wr(dram_mode_pkg::ADDR_TEST, 8'h00);
    wr(dram_mode_pkg::ADDR_TEST, 8'h5a);
    check({trr_en, trr_bank}, 24'hf);
    rd(dram_mode_pkg::ADDR_TEST, 8'h00);
    wr(dram_mode_pkg::ADDR_ACT_TRR, 8'h30);
    check({trr_en, trr_bank}, 24'h3);
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk) repair_available <= 8'h01 << i;
      rd(dram_mode_pkg::ADDR_REPAIR, 8'h01 << i);
    end
    @(posedge mclk) dbi_read_enable <= 1'b0;
    cal(16'h0000, 16'h3c5a, 1'b0);
    wr(dram_mode_pkg::ADDR_LANE_INV_LOW, 8'h01);
    wr(dram_mode_pkg::ADDR_LANE_INV_HIGH, 8'h80);
    wr(dram_mode_pkg::ADDR_CAL_FIRST, 8'h27);
    @(posedge mclk) dbi_read_enable <= 1'b1;
    cal(16'h8001, 16'h3c27, 1'b1);
    ctrl_u.send(dram_mode_pkg::CMD_MPC, 6'h00, 8'h44);
    #1;
    check(dq_oe, 24'h0);
    // mid-run reset restores pattern, invert registers and refresh control
    @(posedge mclk) resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    #1;
    check({trr_en, trr_bank}, 24'h0);
    fork
      cal(16'h0000, 16'h3c5a, 1'b1);
      begin
        // a second start while busy must not restart the readout
        repeat (4) @(posedge mclk);
        ctrl_u.send(dram_mode_pkg::CMD_MPC, 6'h00, 8'h43);
      end
    join
    wrap_up;
  end
endmodule
